// File: hw/dpt_top.sv
`timescale 1ns/1ps
`include "dpt_params.svh"
`default_nettype none
module dpt_top #(
    parameter int unsigned LOST_CYC  = `DPT_LOST_CYC,
    parameter int unsigned PER_EDGES = `DPT_PER_EDGES
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    input  wire dpt_pkg::dpt_avs_req_t avs_req,
    output var  dpt_pkg::dpt_avs_rsp_t avs_rsp,
    input  wire logic [9:0]            pulse_in,
    input  wire logic                  det_start,
    input  wire logic                  det_stop,
    input  wire logic                  prove_i,
    output logic                       prove_o,
    output logic                       prove_oe_n,
    output logic                       irq,
    output logic                       fault_led,
    output logic                       prove_led
);
    import dpt_pkg::*;

    localparam int LW = $clog2(LOST_CYC + 1);
    localparam int EW = $clog2(PER_EDGES);

    if (LOST_CYC < 2 || LW > 30) begin : g_bad_lost
        $error("LOST_CYC out of range");
    end
    if (PER_EDGES < 2 || (PER_EDGES & (PER_EDGES - 1)) != 0) begin : g_bad_per
        $error("PER_EDGES must be a power of two");
    end

    // ----------------------------------------
    // bus slave: one wait cycle per access
    // ----------------------------------------
    logic        ack;
    logic [31:0] rd_q;
    logic [31:0] rdv;
    wire         acc  = avs_req.read | avs_req.write;
    wire         cap  = avs_req.read & !ack;
    wire         wr   = avs_req.write & ack;
    wire [5:0]   widx = avs_req.address[7:2];
    wire [31:0]  wd   = avs_req.writedata;

    assign avs_rsp.waitrequest = acc & !ack;
    assign avs_rsp.readdata    = rd_q;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ack  <= 1'b0;
            rd_q <= 32'h0000_0000;
        end else begin
            ack <= acc & !ack;
            if (cap) begin
                rd_q <= rdv;
            end
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic [4:0]  dual;
    logic        run;
    logic [2:0]  refg;
    logic [2:0]  mask;
    logic [23:0] ph_exp;
    logic [23:0] ph_tol;
    logic [15:0] ulim [5];

    wire [15:0] ulim_in = wd[15:0];
    wire [15:0] ulim_wv = (ulim_in < `DPT_FMIN_HZ) ? `DPT_FMIN_HZ :
                          (ulim_in > `DPT_FMAX_HZ) ? `DPT_FMAX_HZ : ulim_in;
    wire [2:0]  ref_in  = wd[`DPT_C_REF +: 3];
    wire        wr_ctrl = wr && widx == `DPT_IX_CTRL;
    wire        err_clr = wr_ctrl && wd[`DPT_C_CLR];

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            dual   <= 5'h00;
            run    <= 1'b0;
            refg   <= `DPT_REF_RST;
            mask   <= 3'h0;
            ph_exp <= 24'h00_0000;
            ph_tol <= `DPT_PHTOL_RST;
            for (int g = 0; g < 5; g++) begin
                ulim[g] <= `DPT_ULIM_RST;
            end
        end else if (wr) begin
            if (widx == `DPT_IX_CTRL) begin
                dual <= wd[4:0];
                run  <= wd[`DPT_C_RUN];
                refg <= (ref_in > `DPT_REF_MAX) ? `DPT_REF_MAX : ref_in;
            end
            if (widx == `DPT_IX_MASK) begin
                mask <= wd[2:0];
            end
            if (widx == `DPT_IX_PHEXP) begin
                ph_exp <= wd[23:0];
            end
            if (widx == `DPT_IX_PHTOL) begin
                ph_tol <= wd[23:0];
            end
            for (int g = 0; g < 5; g++) begin
                if (widx == `DPT_IX_ULIM + 6'(g)) begin
                    ulim[g] <= ulim_wv;
                end
            end
        end
    end

    // ----------------------------------------
    // per input: sync, width filter, loss, total
    // ----------------------------------------
    logic [9:0]  rise;
    logic [9:0]  lost;
    logic [9:0]  inc_w;
    logic [4:0]  ginc;
    logic [19:0] thr_w [5];
    logic [15:0] tot_w [10];

    for (genvar i = 0; i < 10; i++) begin : gi
        logic          s1;
        logic          s2;
        logic          f;
        logic          fd;
        logic [19:0]   fc;
        logic [LW-1:0] lc;
        logic          lq;
        logic [15:0]   t;

        assign rise[i]  = f & !fd;
        assign lost[i]  = lq;
        assign tot_w[i] = t;
        if (i % 2 == 0) begin : g_a
            assign inc_w[i] = dual[i/2] ? ginc[i/2] : rise[i];
        end else begin : g_b
            assign inc_w[i] = dual[i/2] ? 1'b0 : rise[i];
        end

        // pulses shorter than 15% of the limit period are noise;
        // a source outside that duty would be filtered away
        always_ff @(posedge clk_sys) begin
            if (!rstn) begin
                s1 <= 1'b0;
                s2 <= 1'b0;
                f  <= 1'b0;
                fd <= 1'b0;
                fc <= 20'h0_0000;
            end else begin
                s1 <= pulse_in[i];
                s2 <= s1;
                fd <= f;
                if (s2 == f) begin
                    fc <= 20'h0_0000;
                end else if (fc >= thr_w[i/2] - 20'h0_0001) begin
                    f  <= s2;
                    fc <= 20'h0_0000;
                end else begin
                    fc <= fc + 20'h0_0001;
                end
            end
        end

        always_ff @(posedge clk_sys) begin
            if (!rstn) begin
                lc <= '0;
                lq <= 1'b0;
                t  <= 16'h0000;
            end else begin
                t <= t + 16'(inc_w[i]);
                if (rise[i]) begin
                    lc <= '0;
                    lq <= 1'b0;
                end else if (lc == LW'(LOST_CYC - 1)) begin
                    lq <= 1'b1;
                end else begin
                    lc <= lc + LW'(1);
                end
            end
        end
    end

    // ----------------------------------------
    // per group: pair checking and frequency
    // ----------------------------------------
    logic [15:0] err_w [20];
    logic [31:0] per_w [5];
    logic [4:0]  evany;

    for (genvar g = 0; g < 5; g++) begin : gp
        wire a    = rise[2*g];
        wire b    = rise[2*g+1];
        wire la   = lost[2*g];
        wire degr = la | lost[2*g+1];
        wire live = dual[g] & !degr;
        dpt_pair_st_t  st;
        dpt_pair_st_t  next_st;
        logic [23:0]   ph;
        logic [15:0]   ec [4];
        logic [31:0]   pc;
        logic [31:0]   per;
        logic [EW-1:0] ecnt;
        logic [3:0]    ev;
        wire [23:0]    dif   = (ph > ph_exp) ? ph - ph_exp : ph_exp - ph;
        wire           ph_ok = dif <= ph_tol;
        wire           in_a  = !a & b;
        wire           miss  = live & a & !b & st == PS_WAIT_B;
        wire           good  = live & in_a & st == PS_WAIT_B & ph_ok;
        wire           src   = la ? b : a;

        assign thr_w[g]     = 20'(`DPT_FILT_NUM / 32'(ulim[g]));
        assign ev[ER_COIN]  = live & a & b;
        assign ev[ER_SEQ]   = live & a & !b & st == PS_B_FIRST;
        assign ev[ER_PHASE] = live & in_a & st == PS_WAIT_B & !ph_ok;
        assign ev[ER_ADD]   = live & in_a & st == PS_B_FIRST;
        assign evany[g]     = |ev;
        // a lost side leaves the other counting raw
        assign ginc[g]      = degr ? src : (miss | good);
        assign per_w[g]     = per;
        for (genvar k = 0; k < 4; k++) begin : ge
            assign err_w[g*4+k] = ec[k];
        end

        always_comb begin
            next_st = st;
            case (st)
                PS_IDLE: begin
                    if (a & !b) begin
                        next_st = PS_WAIT_B;
                    end else if (in_a) begin
                        next_st = PS_B_FIRST;
                    end
                end
                PS_WAIT_B: begin
                    if (b) begin
                        next_st = PS_IDLE;
                    end
                end
                PS_B_FIRST: begin
                    if (a) begin
                        next_st = PS_IDLE;
                    end
                end
                default: next_st = PS_IDLE;
            endcase
        end

        always_ff @(posedge clk_sys) begin
            if (!rstn || !live) begin
                st <= PS_IDLE;
                ph <= 24'h00_0000;
            end else begin
                st <= next_st;
                if (a) begin
                    ph <= 24'h00_0000;
                end else if (ph != 24'hFF_FFFF) begin
                    ph <= ph + 24'h00_0001;
                end
            end
        end

        // a clear and an error in one cycle keeps the error
        always_ff @(posedge clk_sys) begin
            for (int k = 0; k < 4; k++) begin
                if (!rstn) begin
                    ec[k] <= 16'h0000;
                end else if (err_clr) begin
                    ec[k] <= 16'(ev[k]);
                end else begin
                    ec[k] <= ec[k] + 16'(ev[k]);
                end
            end
        end

        always_ff @(posedge clk_sys) begin
            if (!rstn) begin
                pc   <= 32'h0000_0000;
                per  <= 32'h0000_0000;
                ecnt <= '0;
            end else if (src) begin
                if (ecnt == EW'(PER_EDGES - 1)) begin
                    per  <= pc + 32'h0000_0001;
                    pc   <= 32'h0000_0000;
                    ecnt <= '0;
                end else begin
                    pc   <= pc + 32'h0000_0001;
                    ecnt <= ecnt + EW'(1);
                end
            end else if (pc != 32'hFFFF_FFFF) begin
                pc <= pc + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------
    // snapshot of all totalizers
    // ----------------------------------------
    logic [15:0] snap [10];
    wire         snap_take = cap && widx == `DPT_IX_TOT;

    always_ff @(posedge clk_sys) begin
        for (int k = 0; k < 10; k++) begin
            if (!rstn) begin
                snap[k] <= 16'h0000;
            end else if (snap_take) begin
                snap[k] <= tot_w[k];
            end
        end
    end

    // ----------------------------------------
    // prover: separate timing, reads pulses only
    // ----------------------------------------
    dpt_prv_st_t pv;
    logic [2:0]  ds;
    logic [2:0]  dp;
    logic [1:0]  pin_s;
    logic [31:0] cht;
    logic [31:0] chi;
    logic        i_on;
    logic        done_ev;
    wire         start_e = ds[1] & !ds[2];
    wire         stop_e  = dp[1] & !dp[2];
    wire         mp      = inc_w[{refg, 1'b0}];
    wire [31:0]  step    = 32'(`DPT_CHRON_STEP);

    assign prove_o    = 1'b0;
    assign prove_oe_n = !run;
    assign prove_led  = pv != PV_IDLE;

    // the prover only reads the pulse stream, nothing flows back
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ds      <= 3'h0;
            dp      <= 3'h0;
            pin_s   <= 2'h0;
            pv      <= PV_IDLE;
            cht     <= 32'h0000_0000;
            chi     <= 32'h0000_0000;
            i_on    <= 1'b0;
            done_ev <= 1'b0;
        end else begin
            ds      <= {ds[1:0], det_start};
            dp      <= {dp[1:0], det_stop};
            pin_s   <= {pin_s[0], prove_i};
            done_ev <= 1'b0;
            case (pv)
                PV_IDLE: begin
                    if (run && start_e) begin
                        pv   <= PV_RUN;
                        cht  <= 32'h0000_0000;
                        chi  <= 32'h0000_0000;
                        i_on <= 1'b0;
                    end
                end
                PV_RUN: begin
                    cht <= cht + step;
                    if (mp) begin
                        i_on <= 1'b1;
                    end
                    if (i_on) begin
                        chi <= chi + step;
                    end
                    if (!run) begin
                        pv <= PV_IDLE;
                    end else if (stop_e) begin
                        pv <= PV_TAIL;
                    end
                end
                PV_TAIL: begin
                    chi <= chi + step;
                    if (!run) begin
                        pv <= PV_IDLE;
                    end else if (mp) begin
                        pv      <= PV_IDLE;
                        done_ev <= 1'b1;
                    end
                end
                default: pv <= PV_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // status and interrupt
    // ----------------------------------------
    logic [2:0] stat;
    logic [9:0] lost_d;
    wire        fault_ev = |(lost & ~lost_d);
    wire [2:0]  st_set   = {|evany, fault_ev, done_ev};
    wire        st_clr   = cap && widx == `DPT_IX_STAT;

    assign irq       = |(stat & mask);
    assign fault_led = |lost;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            stat   <= 3'h0;
            lost_d <= 10'h000;
        end else begin
            lost_d <= lost;
            stat   <= (st_clr ? 3'h0 : stat) | st_set;
        end
    end

    // ----------------------------------------
    // read map
    // ----------------------------------------
    always_comb begin
        rdv = 32'h0000_0000;
        if (widx == `DPT_IX_CTRL) rdv = {23'h0, refg, run, dual};
        if (widx == `DPT_IX_STAT) rdv = {29'h0, stat};
        if (widx == `DPT_IX_MASK) rdv = {29'h0, mask};
        if (widx == `DPT_IX_LIVE) rdv = {20'h0, pin_s[1], prove_led, lost};
        if (widx == `DPT_IX_PHEXP) rdv = {8'h0, ph_exp};
        if (widx == `DPT_IX_PHTOL) rdv = {8'h0, ph_tol};
        if (widx == `DPT_IX_CHT) rdv = cht;
        if (widx == `DPT_IX_CHI) rdv = chi;
        if (widx == `DPT_IX_TOT) rdv = {16'h0, tot_w[0]};
        for (int k = 0; k < 5; k++) begin
            if (widx == `DPT_IX_ULIM + 6'(k)) rdv = {16'h0, ulim[k]};
            if (widx == `DPT_IX_PER + 6'(k)) rdv = per_w[k];
        end
        for (int k = 1; k < 10; k++) begin
            if (widx == `DPT_IX_TOT + 6'(k)) rdv = {16'h0, snap[k]};
        end
        for (int k = 0; k < 20; k++) begin
            if (widx == `DPT_IX_ERR + 6'(k)) rdv = {16'h0, err_w[k]};
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_acc;
        acc && !ack;
    endsequence
    property p_one_wait;
        s_acc |-> avs_rsp.waitrequest ##1 !avs_rsp.waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait cycle count wrong");

    property p_snap_all;
        snap_take |=> snap[9] == $past(tot_w[9]) && snap[1] == $past(tot_w[1]);
    endproperty
    a_snap_all: assert property (p_snap_all) else $error("snapshot not taken");

    // 16-bit sum, so the step from all ones must land on zero
    property p_wrap;
        inc_w[0] |=> tot_w[0] == $past(tot_w[0]) + 16'h0001;
    endproperty
    a_wrap: assert property (p_wrap) else $error("totalizer did not wrap");

    property p_coin;
        gp[2].live && rise[4] && rise[5] && !err_clr
            |=> tot_w[4] == $past(tot_w[4]) && gp[2].ec[0] == $past(gp[2].ec[0]) + 16'h0001;
    endproperty
    a_coin: assert property (p_coin) else $error("coincident pulse handled wrong");

    property p_miss;
        gp[2].live && gp[2].st == PS_WAIT_B && rise[4] && !rise[5]
            |=> tot_w[4] == $past(tot_w[4]) + 16'h0001;
    endproperty
    a_miss: assert property (p_miss) else $error("missing pulse not added");

    property p_degr;
        dual[2] && lost[4] && rise[5] |=> tot_w[4] == $past(tot_w[4]) + 16'h0001 && gp[2].st == PS_IDLE;
    endproperty
    a_degr: assert property (p_degr) else $error("lost signal fallback wrong");

    property p_prove_pin;
        wr_ctrl |=> prove_oe_n == !$past(wd[`DPT_C_RUN]) && !prove_o;
    endproperty
    a_prove_pin: assert property (p_prove_pin) else $error("prove output not as commanded");

    sequence s_run2;
        pv == PV_RUN ##1 pv == PV_RUN;
    endsequence
    property p_chron;
        s_run2 |-> cht == $past(cht) + step;
    endproperty
    a_chron: assert property (p_chron) else $error("chronometry step wrong");

    property p_ulim;
        wr && widx == `DPT_IX_ULIM + 6'h03 && wd[15:0] < `DPT_FMIN_HZ |=> ulim[3] == `DPT_FMIN_HZ;
    endproperty
    a_ulim: assert property (p_ulim) else $error("limit not clamped");
endmodule
`default_nettype wire

// File: pkg/dpt_params.svh
`ifndef DPT_PARAMS_SVH
`define DPT_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define DPT_CLK_HZ       25000000
`define DPT_CHRON_HZ     50000000
`define DPT_CHRON_STEP   (`DPT_CHRON_HZ / `DPT_CLK_HZ)
`define DPT_FMIN_HZ      16'h0005
`define DPT_FMAX_HZ      16'h61A8
`define DPT_DUTY_MIN_PCT 15
`define DPT_FILT_NUM     (`DPT_CLK_HZ / 100 * `DPT_DUTY_MIN_PCT)
`define DPT_LOST_MS      400
`define DPT_LOST_CYC     (`DPT_CLK_HZ / 1000 * `DPT_LOST_MS)
`define DPT_PER_EDGES    16
// ----------------------------------------
// word indexes (byte address = 4 * index)
// ----------------------------------------
`define DPT_IX_CTRL  6'h00
`define DPT_IX_STAT  6'h01
`define DPT_IX_MASK  6'h02
`define DPT_IX_LIVE  6'h03
`define DPT_IX_PHEXP 6'h04
`define DPT_IX_PHTOL 6'h05
`define DPT_IX_ULIM  6'h08
`define DPT_IX_TOT   6'h10
`define DPT_IX_ERR   6'h20
`define DPT_IX_PER   6'h34
`define DPT_IX_CHT   6'h39
`define DPT_IX_CHI   6'h3A
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DPT_C_RUN     5
`define DPT_C_REF     6
`define DPT_C_CLR     9
`define DPT_ST_DONE   0
`define DPT_ST_FAULT  1
`define DPT_ST_ERR    2
`define DPT_REF_RST   3'h4
`define DPT_REF_MAX   3'h4
`define DPT_ULIM_RST  16'h61A8
`define DPT_PHTOL_RST 24'hFF_FFFF
`endif

// File: pkg/dpt_pkg.sv
`default_nettype none
package dpt_pkg;
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } dpt_avs_req_t;
    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } dpt_avs_rsp_t;
    typedef enum logic [1:0] {PS_IDLE, PS_WAIT_B, PS_B_FIRST} dpt_pair_st_t;
    typedef enum logic [1:0] {PV_IDLE, PV_RUN, PV_TAIL} dpt_prv_st_t;
    typedef enum logic [1:0] {ER_COIN, ER_SEQ, ER_PHASE, ER_ADD} dpt_err_t;
endpackage
`default_nettype wire

// File: tb/dpt_field.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// field side: meters and prover detectors
// ----------------------------------------
module dpt_field (
    input  wire logic clk_sys,
    output logic [9:0] pins,
    output logic       det_start,
    output logic       det_stop
);
    initial begin
        pins = 10'h000;
        det_start = 1'b0;
        det_stop = 1'b0;
    end
    // b lags a by gap, both drop together; a 600 clock low keeps the rate under the limit
    task automatic pulse(input logic [9:0] a, input logic [9:0] b, input int gap, input int hi);
        @(posedge clk_sys) pins <= pins | a | (gap == 0 ? b : 10'h000);
        if (gap > 0) begin
            repeat (gap) @(posedge clk_sys);
            pins <= pins | b;
        end
        repeat (hi) @(posedge clk_sys);
        pins <= pins & ~(a | b);
        repeat (600) @(posedge clk_sys);
    endtask
    task automatic strobe(input logic stop);
        @(posedge clk_sys) det_start <= !stop;
        det_stop <= stop;
        repeat (10) @(posedge clk_sys);
        det_start <= 1'b0;
        det_stop <= 1'b0;
        repeat (10) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// File: tb/test_dual_pulse_totalizer_prover.sv
`timescale 1ns/1ps
`default_nettype none
module test_dual_pulse_totalizer_prover;
    import dpt_pkg::*;
    localparam int unsigned LOST = 30000;
    logic                 clk_sys;
    logic                 rstn;
    dpt_avs_req_t         req;
    dpt_avs_rsp_t         rsp;
    logic [9:0]           pins;
    logic                 det_a, det_b, oe_n, p_o, irq, fault_led, prove_led;
    wire                  wire_lvl;
    logic [31:0]          rd;
    int                   n_fail = 0;
    int                   n_compared = 0;
    int                   cyc = 0;
    // open-drain wire with pull-up
    assign wire_lvl = oe_n ? 1'b1 : p_o;
    dpt_top #(.LOST_CYC(LOST), .PER_EDGES(16)) u_dut (
        .clk_sys(clk_sys), .rstn(rstn), .avs_req(req), .avs_rsp(rsp),
        .pulse_in(pins), .det_start(det_a), .det_stop(det_b), .prove_i(wire_lvl),
        .prove_o(p_o), .prove_oe_n(oe_n), .irq(irq), .fault_led(fault_led), .prove_led(prove_led)
    );
    dpt_field u_fld (.clk_sys(clk_sys), .pins(pins), .det_start(det_a), .det_stop(det_b));
    // ----------------------------------------
    // bench tasks
    // ----------------------------------------
    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // waitrequest and read data taken at the rising edge, before its updates land
    task automatic bus(input logic wr, input logic [5:0] ix, input logic [31:0] wd);
        @(posedge clk_sys);
        req <= '{!wr, wr, {ix, 2'b00}, wd};
        @(posedge clk_sys);
        while (rsp.waitrequest !== 1'b0) @(posedge clk_sys);
        rd = rsp.readdata;
        req <= '0;
    endtask
    task automatic rchk(input logic [5:0] ix, input logic [31:0] exp);
        bus(1'b0, ix, 32'h0000_0000);
        chk(rd, exp);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_fail++;
            close_out();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        req = '0;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        chk(oe_n, 1'b1);
        rchk(6'h00, 32'h0000_0100);
        rchk(6'h02, 32'h0000_0000);
        rchk(6'h05, 32'h00FF_FFFF);
        rchk(6'h08, 32'h0000_61A8);
        rchk(6'h06, 32'h0000_0000);
        bus(1'b1, 6'h0B, 32'h0000_0000);
        rchk(6'h0B, 32'h0000_0005);
        bus(1'b1, 6'h0B, 32'h0000_7530);
        rchk(6'h0B, 32'h0000_61A8);
        @(negedge clk_sys);
        chk(fault_led, 1'b0);
        // single mode, synchronized snapshot
        u_fld.pulse(10'h009, 10'h000, 0, 400);
        u_fld.pulse(10'h001, 10'h000, 0, 400);
        u_fld.pulse(10'h002, 10'h000, 0, 50);
        rchk(6'h10, 32'h0000_0002);
        u_fld.pulse(10'h008, 10'h000, 0, 400);
        rchk(6'h13, 32'h0000_0001);
        rchk(6'h11, 32'h0000_0000);
        rchk(6'h10, 32'h0000_0002);
        rchk(6'h13, 32'h0000_0002);
        // dual pair on group 2: good, missing, coincident
        bus(1'b1, 6'h00, 32'h0000_0104);
        u_fld.pulse(10'h010, 10'h020, 100, 400);
        u_fld.pulse(10'h010, 10'h000, 0, 400);
        u_fld.pulse(10'h010, 10'h020, 100, 400);
        u_fld.pulse(10'h030, 10'h000, 0, 400);
        rchk(6'h10, 32'h0000_0002);
        rchk(6'h14, 32'h0000_0003);
        rchk(6'h15, 32'h0000_0000);
        rchk(6'h28, 32'h0000_0001);
        rchk(6'h29, 32'h0000_0000);
        // pair error interrupt, sticky until read
        chk(irq, 1'b0);
        bus(1'b1, 6'h02, 32'h0000_0004);
        @(negedge clk_sys);
        chk(irq, 1'b1);
        bus(1'b0, 6'h01, 32'h0000_0000);
        chk(rd & 32'h0000_0004, 32'h0000_0004);
        @(negedge clk_sys);
        chk(irq, 1'b0);
        bus(1'b1, 6'h00, 32'h0000_0304);
        rchk(6'h28, 32'h0000_0000);
        // proving run on reference group 4
        bus(1'b1, 6'h00, 32'h0000_0124);
        @(negedge clk_sys);
        chk(oe_n, 1'b0);
        // wire level needs the two sync flops before it reads back
        repeat (2) @(posedge clk_sys);
        bus(1'b0, 6'h03, 32'h0000_0000);
        chk(rd & 32'h0000_0800, 32'h0000_0000);
        u_fld.strobe(1'b0);
        u_fld.pulse(10'h100, 10'h000, 0, 400);
        chk(prove_led, 1'b1);
        u_fld.strobe(1'b1);
        u_fld.pulse(10'h100, 10'h000, 0, 400);
        bus(1'b0, 6'h01, 32'h0000_0000);
        chk(rd & 32'h0000_0001, 32'h0000_0001);
        bus(1'b0, 6'h39, 32'h0000_0000);
        // about 1022 clocks between detectors, two counts each
        chk(rd >= 32'h0000_07EE && rd <= 32'h0000_080C && !rd[0], 1'b1);
        // reference pulses 1022 clocks apart, same filter delay on both
        rchk(6'h3A, 32'h0000_07FC);
        rchk(6'h10, 32'h0000_0002);
        rchk(6'h18, 32'h0000_0002);
        bus(1'b1, 6'h00, 32'h0000_0104);
        @(negedge clk_sys);
        chk(oe_n, 1'b1);
        // silence until every input counts as lost
        repeat (LOST + 200) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(fault_led, 1'b1);
        bus(1'b0, 6'h03, 32'h0000_0000);
        chk(rd & 32'h0000_0210, 32'h0000_0210);
        // pair 2 with A lost keeps counting B alone
        u_fld.pulse(10'h020, 10'h000, 0, 400);
        rchk(6'h10, 32'h0000_0002);
        rchk(6'h14, 32'h0000_0004);
        rchk(6'h28, 32'h0000_0000);
        close_out();
    end
endmodule
`default_nettype wire
